/* File: bench/test_voltage_code_receiver.sv */
// Bench for the host and receiver joined by the code link
`timescale 1ns/1ps
module test_voltage_code_receiver;
	localparam int          HOLD = 40;
	localparam logic [15:0] LO   = 16'h0100;
	localparam logic [15:0] SS   = 16'h0180;
	logic               sys_clk_i  = 1'b0;
	logic               resetn_i   = 1'b0;
	logic [3:0]         adr        = 4'h0;
	logic               rd         = 1'b0;
	logic               wr         = 1'b0;
	logic [31:0]        wdat       = 32'h0000_0000;
	logic [31:0]        rdat;
	logic               wreq;
	logic [1:0]         fmt;
	logic [15:0]        hi;
	logic signed [15:0] lock;
	logic [7:0]         ini;
	logic [1:0]         en;
	logic [1:0]         cw         = 2'h0;
	logic [7:0]         cdat       = 8'h00;
	logic [1:0][15:0]   sp;
	logic [1:0][7:0]    code;
	logic [1:0]         live;
	logic [31:0]        q;
	int                 errors     = 0;
	int                 n_compared = 0;
	int                 n;

	vcr_if #(.RAILS(2)) link ();
	vcr_host #(.RAILS(2), .HOLD_CYC(HOLD)) vcr_host_inst (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .link(link));
	vcr_device #(.RAILS(2), .VW(16), .MS_CYC(50), .POLL_CYC(20), .STABLE_CYC(25))
		vcr_device_inst (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link(link), .code_width_field_i(fmt),
		.code_upper_limit_i(hi), .code_lower_limit_i(LO), .init_code_i(ini),
		.softstart_v_i(SS), .lockout_ms_i(lock), .output_slew_rate_i(16'h0010),
		.rail_en_i(en), .rail_code_write_i(cw), .rail_code_data_i(cdat),
		.setpoint_o(sp), .code_o(code), .codes_live_o(live));
	vcr_link_props #(.RAILS(2), .HOLD_CYC(HOLD)) vcr_link_props_inst (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .code_line_a(link.code_line_a),
		.code_line_b(link.code_line_b), .code_line_c(link.code_line_c),
		.code_select_line(link.code_select_line));

	always #5 sys_clk_i = ~sys_clk_i;

	// ****
	// Access, wait and compare tasks
	// ****
	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	task automatic chk_val(input logic [15:0] g, input logic [15:0] e, input string s);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, s, g, e);
		end
	endtask : chk_val

	task automatic chk_rng(input int g, input int lo, input int hi_b, input string s);
		n_compared++;
		if (g < lo || g > hi_b) begin
			errors++;
			$display("wrong value at %0t: %s took %0d cycles", $time, s, g);
		end
	endtask : chk_rng

	task automatic cfg(input logic [1:0] f, input logic [15:0] h, input logic signed [15:0] l,
		input logic [7:0] c);
		fmt <= f;
		hi <= h;
		lock <= l;
		ini <= c;
	endtask : cfg

	task automatic power(input logic [1:0] e);
		en <= e;
	endtask : power

	task automatic put_code(input int r, input logic [7:0] d);
		cdat <= d;
		cw <= 2'(1 << r);
		@(posedge sys_clk_i);
		cw <= 2'h0;
	endtask : put_code

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		@(posedge sys_clk_i);
		while (wreq !== 1'b0 && k < 5000) begin
			@(posedge sys_clk_i);
			k++;
		end
		if (k >= 5000) begin
			errors++;
			$display("wrong value at %0t: bus access timed out", $time);
		end
		r = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge sys_clk_i);
	endtask : bus

	task automatic idle;
		int k;
		k = 0;
		q = 32'h0000_0001;
		while (q[1:0] !== 2'b00 && k < 200) begin
			bus(1'b0, 4'hC, 32'h0000_0000, q);
			k++;
		end
	endtask : idle

	task automatic wait_sp(input int r, input logic [15:0] e, output int c);
		c = 0;
		while (sp[r] !== e && c < 9000) begin
			@(posedge sys_clk_i);
			c++;
		end
	endtask : wait_sp

	task automatic wait_live(input int r, output int c);
		c = 0;
		while (live[r] !== 1'b1 && c < 500) begin
			@(posedge sys_clk_i);
			c++;
		end
	endtask : wait_live

	task automatic wait_sel(input int r, input logic v);
		int k;
		k = 0;
		while (link.code_select_line[r] !== v && k < 500) begin
			@(posedge sys_clk_i);
			k++;
		end
	endtask : wait_sel

	function automatic logic [15:0] lines(input int r);
		return {12'h000, link.code_select_line[r], link.code_line_c[r], link.code_line_b[r],
			link.code_line_a[r]};
	endfunction : lines

	initial begin
		repeat (80000) @(posedge sys_clk_i);
		errors++;
		$display("wrong value at %0t: run hung", $time);
		give_verdict();
	end

	// ****
	// Test sequence
	// ****
	initial begin
		cfg(2'h0, 16'h01F0, 16'sh0002, 8'h03);
		power(2'b00);
		repeat (4) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		bus(1'b1, 4'h2, 32'hFFFF_FFFF, q);
		bus(1'b0, 4'h2, 32'h0000_0000, q);
		chk_val(q[15:0], 16'h0000, "unmapped");
		bus(1'b1, 4'h0, 32'h0000_0000, q);
		bus(1'b0, 4'hC, 32'h0000_0000, q);
		chk_val(q[15:0], 16'h0000, "status idle");
		$display("test registers done");
		power(2'b11);
		wait_sp(0, SS, n);
		chk_val(sp[0], SS, "ramp top");
		chk_val({8'h00, code[0]}, 16'h0003, "initial code");
		wait_live(0, n);
		chk_rng(n, 98, 103, "lockout");
		$display("test power up done");
		bus(1'b1, 4'h4, 32'h0000_000B, q);
		wait_sp(0, LO + 16'h00B0, n);
		chk_rng(n, 3515, 4400, "4-bit delay");
		chk_val(sp[0], LO + 16'h00B0, "4-bit setpoint");
		chk_val(lines(0), 16'h000B, "4-bit lines");
		bus(1'b0, 4'h4, 32'h0000_0000, q);
		chk_val(q[15:0], 16'h000B, "sent code");
		bus(1'b1, 4'h8, 32'h0000_0005, q);
		wait_sp(1, LO + 16'h0050, n);
		chk_val(sp[1], LO + 16'h0050, "rail 1 setpoint");
		chk_val({8'h00, code[1]}, 16'h0005, "rail 1 code");
		chk_val({8'h00, code[0]}, 16'h000B, "rail 0 kept");
		$display("test 4-bit done");
		idle();
		bus(1'b1, 4'h0, 32'h0000_0001, q);
		bus(1'b0, 4'h0, 32'h0000_0000, q);
		chk_val(q[15:0], 16'h0001, "mode");
		cfg(2'h1, 16'h01FC, lock, ini);
		bus(1'b1, 4'h4, 32'h0000_002E, q);
		bus(1'b0, 4'hC, 32'h0000_0000, q);
		chk_val(q[15:0] & 16'h0001, 16'h0001, "busy");
		wait_sel(0, 1'b0);
		chk_val(lines(0), 16'h0006, "low half");
		wait_sel(0, 1'b1);
		chk_val(lines(0), 16'h000D, "high half");
		wait_sp(0, LO + 16'h00B8, n);
		chk_rng(n, 3495, 3700, "6-bit delay");
		chk_val(sp[0], LO + 16'h00B8, "6-bit setpoint");
		bus(1'b1, 4'h4, 32'h0000_003F, q);
		bus(1'b1, 4'h4, 32'h0000_003F, q);
		wait_sp(0, LO + 16'h00FC, n);
		chk_val(sp[0], LO + 16'h00FC, "top code");
		bus(1'b1, 4'h4, 32'h0000_0000, q);
		wait_sp(0, LO, n);
		chk_val(sp[0], LO, "zero code");
		$display("test 6-bit done");
		idle();
		cfg(2'h2, 16'h01FF, lock, ini);
		put_code(0, 8'hA5);
		wait_sp(0, LO + 16'h00A5, n);
		chk_val(sp[0], LO + 16'h00A5, "8-bit setpoint");
		bus(1'b1, 4'h4, 32'h0000_0015, q);
		repeat (4000) @(posedge sys_clk_i);
		chk_val(sp[0], LO + 16'h00A5, "lines ignored");
		$display("test 8-bit done");
		cfg(fmt, hi, 16'shFFFF, ini);
		power(2'b00);
		repeat (3) @(posedge sys_clk_i);
		chk_val({14'h0000, live}, 16'h0003, "always live");
		cfg(fmt, hi, 16'sh0000, 8'h07);
		repeat (3) @(posedge sys_clk_i);
		chk_val({14'h0000, live}, 16'h0000, "off not live");
		power(2'b01);
		wait_sp(0, SS, n);
		chk_val({8'h00, code[0]}, 16'h0007, "new initial code");
		wait_live(0, n);
		chk_rng(n, 0, 3, "zero lockout");
		$display("test lockout modes done");
		give_verdict();
	end
endmodule : test_voltage_code_receiver

/* File: bench/vcr_link_props.sv */
// Checker for the code lines between host and receiver
`timescale 1ns/1ps
module vcr_link_props #(
	parameter int RAILS    = 2,
	parameter int HOLD_CYC = vcr_pkg::HOLD_CYC
) (
	input wire logic             sys_clk_i,
	input wire logic             resetn_i,
	input wire logic [RAILS-1:0] code_line_a,
	input wire logic [RAILS-1:0] code_line_b,
	input wire logic [RAILS-1:0] code_line_c,
	input wire logic [RAILS-1:0] code_select_line
);
	localparam int MIN_CYC = HOLD_CYC * vcr_pkg::MIN_HOLD_US / vcr_pkg::HOLD_US;
	logic [3:0] ln0;
	logic [3:0] ln1;
	logic [3:0] prv_r [2];
	int         cnt_r [2];

	assign ln0 = {code_select_line[0], code_line_c[0], code_line_b[0], code_line_a[0]};
	assign ln1 = {code_select_line[1], code_line_c[1], code_line_b[1], code_line_a[1]};

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	// ****
	// Cycles since each rail's lines last moved
	// ****
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r <= '{HOLD_CYC, HOLD_CYC};
			prv_r <= '{4'h8, 4'h8};
		end else begin
			cnt_r[0] <= (ln0 != prv_r[0]) ? 1 : cnt_r[0] + 1;
			cnt_r[1] <= (ln1 != prv_r[1]) ? 1 : cnt_r[1] + 1;
			prv_r    <= '{ln0, ln1};
		end
	end

	sequence sel_edge0_s; $changed(code_select_line[0]); endsequence
	sequence sel_edge1_s; $changed(code_select_line[1]); endsequence
	sequence quiet0_s; $stable(ln0) [*8]; endsequence
	sequence quiet1_s; $stable(ln1) [*8]; endsequence

	AST_MIN_HOLD_R0: assert property ($changed(ln0) |-> cnt_r[0] >= MIN_CYC)
		else $error("rail 0 lines moved too soon");
	AST_MIN_HOLD_R1: assert property ($changed(ln1) |-> cnt_r[1] >= MIN_CYC)
		else $error("rail 1 lines moved too soon");
	AST_SUST_HOLD_R0: assert property ($changed(ln0) |-> cnt_r[0] >= HOLD_CYC)
		else $error("rail 0 hold shorter than sustained figure");
	AST_SUST_HOLD_R1: assert property ($changed(ln1) |-> cnt_r[1] >= HOLD_CYC)
		else $error("rail 1 hold shorter than sustained figure");
	AST_SEL_QUIET_R0: assert property (sel_edge0_s |=> quiet0_s)
		else $error("rail 0 lines moved right after select edge");
	AST_SEL_QUIET_R1: assert property (sel_edge1_s |=> quiet1_s)
		else $error("rail 1 lines moved right after select edge");
	AST_IDLE_START: assert property ($rose(resetn_i) |-> ln0 == 4'h8 && ln1 == 4'h8)
		else $error("lines not idle after reset");
	AST_START_STILL: assert property ($rose(resetn_i) |=> $stable(ln0) && $stable(ln1))
		else $error("lines moved at first edge after reset");
endmodule : vcr_link_props

/* File: hw/vcr_device.sv */
// Voltage code receiver: per-rail capture, lockout, setpoint and slew
`timescale 1ns/1ps
module vcr_device #(
	parameter int RAILS      = 2,
	parameter int VW         = 16,
	parameter int MS_CYC     = vcr_pkg::MS_CYC,
	parameter int POLL_CYC   = vcr_pkg::POLL_CYC,
	parameter int STABLE_CYC = vcr_pkg::STABLE_CYC
) (
	input  wire logic                       sys_clk_i,
	input  wire logic                       resetn_i,
	vcr_if.dev_mp                           link,
	input  wire logic [1:0]                 code_width_field_i,
	input  wire logic [VW-1:0]              code_upper_limit_i,
	input  wire logic [VW-1:0]              code_lower_limit_i,
	input  wire logic [7:0]                 init_code_i,
	input  wire logic [VW-1:0]              softstart_v_i,
	input  wire logic signed [15:0]         lockout_ms_i,
	input  wire logic [VW-1:0]              output_slew_rate_i,
	input  wire logic [RAILS-1:0]           rail_en_i,
	input  wire logic [RAILS-1:0]           rail_code_write_i,
	input  wire logic [7:0]                 rail_code_data_i,
	output logic      [RAILS-1:0][VW-1:0]   setpoint_o,
	output logic      [RAILS-1:0][7:0]      code_o,
	output logic      [RAILS-1:0]           codes_live_o
);
	localparam int MSW = $clog2(MS_CYC + 1);
	localparam int PLW = $clog2(POLL_CYC + 1);
	localparam int STW = $clog2(STABLE_CYC + 1);
	localparam int CPW = $clog2(vcr_pkg::COMPUTE_CYC + 1);
	localparam int USW = $clog2(vcr_pkg::US_CYC + 1);

	// ****************************************************************
	// Setpoint from code
	// ****************************************************************
	function automatic logic [VW-1:0] vcr_ref(input logic [7:0] code);
		logic [VW+7:0] prod;
		logic [VW+7:0] quo;
		prod = code * (code_upper_limit_i - code_lower_limit_i);
		case (code_width_field_i)
			vcr_pkg::FMT_4: quo = prod / (VW+8)'(15);
			vcr_pkg::FMT_6: quo = prod / (VW+8)'(63);
			default:        quo = prod / (VW+8)'(255);
		endcase
		return VW'(quo) + code_lower_limit_i; // RQ3
	endfunction : vcr_ref

	// ****************************************************************
	// One receiver per rail
	// ****************************************************************
	for (genvar g = 0; g < RAILS; g++) begin : g_rail // RQ20
		logic [3:0]         ln;
		logic [3:0]         ln_d_r;
		vcr_pkg::vcr_rail_e state_r;
		logic [MSW-1:0]     ms_pre_r;
		logic [14:0]        ms_cnt_r;
		logic [PLW-1:0]     poll_r;
		logic [STW-1:0]     stab_r;
		logic [CPW-1:0]     comp_r;
		logic               comp_busy_r;
		logic [USW-1:0]     us_r;
		logic [7:0]         code_r;
		logic [2:0]         lo_r;
		logic               lo_ok_r;
		logic [VW-1:0]      tgt_r;
		logic [VW-1:0]      sp_r;
		logic [VW-1:0]      goal;
		logic               live;
		logic               fall;
		logic               rise;
		logic               poll_tick;
		logic               stable;
		logic               us_tick;
		logic               en;

		// Reset to the idle line levels so no false select edge follows reset
		vcr_sync #(.W(4), .RST({vcr_pkg::HOST_SEL_RST, 3'b000})) u_sync (
			.sys_clk_i (sys_clk_i),
			.resetn_i  (resetn_i),
			.d_i       ({link.code_select_line[g], link.code_line_c[g],
			             link.code_line_b[g], link.code_line_a[g]}), // RQ19
			.q_o       (ln)
		);

		assign en        = rail_en_i[g];
		assign live      = (state_r == vcr_pkg::VCR_RUN) || lockout_ms_i[15]; // RQ7
		assign fall      = ln_d_r[3] && !ln[3]; // RQ13
		assign rise      = !ln_d_r[3] && ln[3]; // RQ14
		assign poll_tick = (poll_r == PLW'(POLL_CYC - 1));
		assign stable    = (stab_r == STW'(STABLE_CYC));
		assign us_tick   = (us_r == USW'(vcr_pkg::US_CYC - 1));
		assign goal      = (state_r == vcr_pkg::VCR_RUN) ? tgt_r : softstart_v_i;

		// ************************************************************
		// Power state and lockout
		// ************************************************************
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				state_r <= vcr_pkg::VCR_OFF;
			end else if (!en) begin
				state_r <= vcr_pkg::VCR_OFF;
			end else begin
				case (state_r)
					vcr_pkg::VCR_OFF: state_r <= vcr_pkg::VCR_RAMP; // RQ5
					vcr_pkg::VCR_RAMP: begin
						if (sp_r == softstart_v_i) begin
							state_r <= (lockout_ms_i > 16'sd0) ? vcr_pkg::VCR_LOCK
							                                  : vcr_pkg::VCR_RUN; // RQ7
						end
					end
					vcr_pkg::VCR_LOCK: begin
						if (ms_cnt_r == lockout_ms_i[14:0]) begin
							state_r <= vcr_pkg::VCR_RUN; // RQ6
						end
					end
					vcr_pkg::VCR_RUN: state_r <= vcr_pkg::VCR_RUN;
					default: state_r <= vcr_pkg::VCR_OFF;
				endcase
			end
		end

		// Millisecond count from the top of the ramp
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				ms_pre_r <= '0;
				ms_cnt_r <= '0;
			end else if (state_r != vcr_pkg::VCR_LOCK) begin
				ms_pre_r <= '0;
				ms_cnt_r <= '0;
			end else if (ms_pre_r == MSW'(MS_CYC - 1)) begin
				ms_pre_r <= '0;
				ms_cnt_r <= ms_cnt_r + 15'h0001; // RQ6
			end else begin
				ms_pre_r <= ms_pre_r + MSW'(1);
			end
		end

		// ************************************************************
		// Line sampling
		// ************************************************************
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				ln_d_r <= {vcr_pkg::HOST_SEL_RST, 3'b000};
				stab_r <= '0;
				poll_r <= '0;
			end else begin
				ln_d_r <= ln;
				poll_r <= poll_tick ? '0 : poll_r + PLW'(1); // RQ9
				if (ln != ln_d_r) begin
					stab_r <= '0; // RQ10
				end else if (!stable) begin
					stab_r <= stab_r + STW'(1);
				end
			end
		end

		// ************************************************************
		// Code capture
		// ************************************************************
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				code_r      <= vcr_pkg::CODE_RST;
				lo_r        <= '0;
				lo_ok_r     <= 1'b0;
				comp_busy_r <= 1'b0;
			end else begin
				comp_busy_r <= comp_busy_r && (comp_r != CPW'(vcr_pkg::COMPUTE_CYC - 1));
				if (state_r == vcr_pkg::VCR_OFF && !lockout_ms_i[15]) begin
					code_r  <= init_code_i; // RQ4
					lo_ok_r <= 1'b0;
				end else if (live) begin
					case (code_width_field_i) // RQ1
						vcr_pkg::FMT_4: begin
							if (poll_tick && stable && ln != code_r[3:0]) begin
								code_r      <= {4'h0, ln}; // RQ8
								comp_busy_r <= 1'b1;
							end
						end
						vcr_pkg::FMT_6: begin
							if (fall) begin
								lo_r    <= ln[2:0]; // RQ12
								lo_ok_r <= 1'b1;
							end else if (rise && lo_ok_r) begin
								code_r      <= {2'b00, ln[2:0], lo_r}; // RQ14
								comp_busy_r <= 1'b1;
								lo_ok_r     <= 1'b0;
							end
						end
						default: begin
							if (rail_code_write_i[g]) begin
								code_r      <= rail_code_data_i; // RQ18
								comp_busy_r <= 1'b1;
							end
						end
					endcase
				end
			end
		end

		// Computation delay before the new target is applied
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				comp_r <= '0;
				tgt_r  <= '0;
			end else if (state_r == vcr_pkg::VCR_OFF) begin
				comp_r <= '0;
				tgt_r  <= softstart_v_i;
			end else if (comp_busy_r) begin
				comp_r <= comp_r + CPW'(1);
				if (comp_r == CPW'(vcr_pkg::COMPUTE_CYC - 1)) begin
					tgt_r <= vcr_ref(code_r); // RQ3
				end
			end else begin
				comp_r <= '0;
			end
		end

		// ************************************************************
		// Slew toward the goal, one step per microsecond
		// ************************************************************
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				us_r <= '0;
				sp_r <= '0;
			end else if (state_r == vcr_pkg::VCR_OFF) begin
				us_r <= '0;
				sp_r <= '0;
			end else begin
				us_r <= us_tick ? '0 : us_r + USW'(1);
				if (us_tick) begin
					if (output_slew_rate_i == '0) begin
						sp_r <= goal;
					end else if (sp_r < goal) begin
						sp_r <= (goal - sp_r <= output_slew_rate_i) ? goal
						        : sp_r + output_slew_rate_i; // RQ11
					end else if (sp_r > goal) begin
						sp_r <= (sp_r - goal <= output_slew_rate_i) ? goal
						        : sp_r - output_slew_rate_i; // RQ11
					end
				end
			end
		end

		assign setpoint_o[g]   = sp_r;
		assign code_o[g]       = code_r;
		assign codes_live_o[g] = live;
	end
endmodule : vcr_device

/* File: hw/vcr_host.sv */
// Host end: Avalon-MM registers and per-rail code line driver
`timescale 1ns/1ps
module vcr_host #(
	parameter int RAILS    = 2,
	parameter int HOLD_CYC = vcr_pkg::HOLD_CYC
) (
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	vcr_if.host_mp           link
);
	localparam int HW = $clog2(HOLD_CYC + 1);

	logic             mode6_r;
	logic             ack_r;
	logic [RAILS-1:0] busy;
	logic [RAILS-1:0] hit;
	logic [RAILS-1:0][7:0] sent;
	logic             req;

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	assign req               = avs_read_i || avs_write_i;
	assign avs_waitrequest_o = req && !ack_r;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_r          <= 1'b0;
			avs_readdata_o <= '0;
		end else begin
			ack_r <= req && !ack_r && !(|(hit & busy));
			if (avs_read_i && !ack_r) begin
				if (avs_address_i == vcr_pkg::HOST_MODE_OFS) begin
					avs_readdata_o <= {31'h0000_0000, mode6_r};
				end else if (avs_address_i == vcr_pkg::HOST_STATUS_OFS) begin
					avs_readdata_o <= 32'(busy);
				end else begin
					avs_readdata_o <= '0;
					for (int r = 0; r < RAILS; r++) begin
						if (avs_address_i == 4'(vcr_pkg::HOST_CODE0_OFS + 4 * r)) begin
							avs_readdata_o <= {24'h00_0000, sent[r]};
						end
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode6_r <= 1'b0;
		end else if (avs_write_i && ack_r && avs_address_i == vcr_pkg::HOST_MODE_OFS
		             && busy == '0) begin
			mode6_r <= avs_writedata_i[0];
		end
	end

	// ****************************************************************
	// One line driver per rail
	// ****************************************************************
	for (genvar g = 0; g < RAILS; g++) begin : g_tx
		vcr_pkg::vcr_send_e st_r;
		logic [HW-1:0]      hold_r;
		logic [7:0]         send_r;
		logic [3:0]         ln_r;
		logic               start;
		logic               held;

		assign hit[g]  = avs_write_i && avs_address_i == 4'(vcr_pkg::HOST_CODE0_OFS + 4 * g);
		assign start   = hit[g] && ack_r && avs_writedata_i[7:0] != send_r; // RQ17
		assign held    = (hold_r == HW'(HOLD_CYC - 1)); // RQ15 RQ16
		assign busy[g] = (st_r != vcr_pkg::VCR_IDLE);
		assign sent[g] = send_r;

		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				st_r   <= vcr_pkg::VCR_IDLE;
				hold_r <= '0;
				send_r <= vcr_pkg::CODE_RST;
				ln_r   <= {vcr_pkg::HOST_SEL_RST, 3'b000};
			end else begin
				hold_r <= (st_r == vcr_pkg::VCR_IDLE || held) ? '0 : hold_r + HW'(1);
				case (st_r)
					vcr_pkg::VCR_IDLE: begin
						if (start) begin
							send_r <= avs_writedata_i[7:0];
							if (mode6_r) begin
								ln_r <= {1'b0, avs_writedata_i[2:0]}; // RQ12
								st_r <= vcr_pkg::VCR_LO;
							end else begin
								ln_r <= avs_writedata_i[3:0]; // RQ8
								st_r <= vcr_pkg::VCR_HI;
							end
						end
					end
					vcr_pkg::VCR_LO: begin
						if (held) begin
							ln_r <= {1'b1, send_r[5:3]}; // RQ12
							st_r <= vcr_pkg::VCR_HI;
						end
					end
					vcr_pkg::VCR_HI: begin
						if (held) begin
							st_r <= vcr_pkg::VCR_IDLE;
						end
					end
					default: st_r <= vcr_pkg::VCR_IDLE;
				endcase
			end
		end

		assign link.code_line_a[g]      = ln_r[0]; // RQ2
		assign link.code_line_b[g]      = ln_r[1];
		assign link.code_line_c[g]      = ln_r[2];
		assign link.code_select_line[g] = ln_r[3];
	end
endmodule : vcr_host

/* File: hw/vcr_if.sv */
// Four code lines per rail between host and receiver
`timescale 1ns/1ps
interface vcr_if #(
	parameter int RAILS = 2
);
	logic [RAILS-1:0] code_line_a;
	logic [RAILS-1:0] code_line_b;
	logic [RAILS-1:0] code_line_c;
	logic [RAILS-1:0] code_select_line;

	modport host_mp (
		output code_line_a,
		output code_line_b,
		output code_line_c,
		output code_select_line
	);

	modport dev_mp (
		input  code_line_a,
		input  code_line_b,
		input  code_line_c,
		input  code_select_line
	);
endinterface : vcr_if

/* File: hw/vcr_pkg.sv */
// Constants shared by both ends of the voltage code link
// Behaviour
// [RQ1] Codes are 4, 6 or 8 bits wide
// [RQ2] 4/6-bit: three data lines plus select
// [RQ3] Setpoint is code times slope plus lower limit
// [RQ4] Configuration gives initial code, ramp top, lockout
// [RQ5] Lockout starts at top of each soft-start ramp
// [RQ6] Positive lockout delays codes by N milliseconds
// [RQ7] Zero enables at top; negative always live
// [RQ8] 4-bit: a,b,c bits 0-2, select bit 3
// [RQ9] 4-bit lines are levels polled every 400 us
// [RQ10] 4-bit change accepted after 500 us stable
// [RQ11] Setpoint slews at configured rate, never steps; setpoint jumps straight to goal when the rate is zero
// [RQ12] 6-bit: select low bits 2:0, high 5:3
// [RQ13] 6-bit select fall captures bits 2:0
// [RQ14] 6-bit select rise captures 5:3, computes setpoint
// [RQ15] Host holds lines 70 us after select change
// [RQ16] Host holds 125 us for sustained transfers
// [RQ17] Host sends only codes that changed
// [RQ18] 8-bit: lines ignored, code written by command
// [RQ19] Code lines pass a synchroniser first
// [RQ20] Each rail has its own independent receiver
package vcr_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ     = 100;
	localparam int US_CYC      = CLK_MHZ;
	localparam int MS_CYC      = 1000 * CLK_MHZ;
	localparam int POLL_US     = 400;
	localparam int POLL_CYC    = POLL_US * CLK_MHZ;
	localparam int STABLE_US   = 500;
	localparam int STABLE_CYC  = STABLE_US * CLK_MHZ;
	localparam int COMPUTE_US  = 35;
	localparam int COMPUTE_CYC = COMPUTE_US * CLK_MHZ;
	localparam int MIN_HOLD_US = 70;
	localparam int HOLD_US     = 125;
	localparam int HOLD_CYC    = HOLD_US * CLK_MHZ;

	// ****************************************************************
	// Code width field encodings
	// ****************************************************************
	localparam logic [1:0] FMT_4 = 2'h0;
	localparam logic [1:0] FMT_6 = 2'h1;
	localparam logic [1:0] FMT_8 = 2'h2;

	// ****************************************************************
	// Host register map and reset values
	// ****************************************************************
	localparam logic [3:0] HOST_MODE_OFS   = 4'h0;
	localparam logic [3:0] HOST_CODE0_OFS  = 4'h4;
	localparam logic [3:0] HOST_STATUS_OFS = 4'hC;
	localparam logic       HOST_SEL_RST    = 1'b1;
	localparam logic [7:0] CODE_RST        = 8'h00;

	// ****************************************************************
	// State types
	// ****************************************************************
	typedef enum logic [1:0] {
		VCR_OFF  = 2'b00,
		VCR_RAMP = 2'b01,
		VCR_LOCK = 2'b11,
		VCR_RUN  = 2'b10
	} vcr_rail_e;

	typedef enum logic [1:0] {
		VCR_IDLE = 2'b00,
		VCR_LO   = 2'b01,
		VCR_HI   = 2'b11
	} vcr_send_e;

endpackage : vcr_pkg

/* File: hw/vcr_sync.sv */
// Two-flop synchroniser for asynchronous lines
`timescale 1ns/1ps
module vcr_sync #(
	parameter int           W   = 4,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         sys_clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_r <= RST;
			q_o    <= RST;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule : vcr_sync
